/* File: rtl/ahpc_pkg.sv */
// package: constants for the adc host port and interface control register
package ahpc_pkg;
  localparam int AHPC_WORD_W = 12;
  localparam int AHPC_DATA_W = 10;
  // address bits of a control word
  localparam int AHPC_ADDR_HI_POS = 11;
  localparam int AHPC_ADDR_LO_POS = 10;
  // interface_and_format_control field positions
  localparam int AHPC_DEV_RESET_POS = 0;
  localparam int AHPC_SYNC_CLR_POS = 1;
  localparam int AHPC_DIR_MODE_POS = 6;
  localparam int AHPC_FMT_POS = 7;
  localparam int AHPC_OFFS_POS = 8;
  // reset values of control registers
  localparam logic [11:0] AHPC_CR1_RESET = 12'h030;
  localparam logic [9:0] AHPC_CR0_RESET = 10'h020;
  // format flip for straight binary: invert msb of two's complement
  localparam logic [9:0] AHPC_MSB_FLIP = 10'h200;
  localparam logic [9:0] AHPC_ZERO_W = 10'h000;
endpackage

/* File: rtl/ahpc_host_port.sv */
// module: parallel host port, strobe logic and interface control register
//
// Overview of operation
// R1 - control register one is write-only, addr 01
// R2 - reset bit one resets device and registers
// R3 - device stays in reset until bit0 cleared
// R4 - bit1 set clears the sync generator
// R5 - host sets sync clear for multichannel setup
// R6 - host writes reserved bit 9 as zero
// R7 - bit6 one: write pin is read-not-write
// R8 - bit6 zero: separate read and write pins
// R9 - bit7 selects two's complement or binary
// R10 - bit8 captures offset, subtracts from results
// R11 - read strobe on last active, write idle
// R12 - read strobe drops on first inactive
// R13 - read strobe drives data and enables drivers
// R14 - write strobe on last active, read idle
// R15 - write strobe drops on first inactive
// R16 - write strobe loads control register word
// R17 - host writes reserved bits 2..5 as reset
// R18 - host holds read pin high in combined mode
`timescale 1ns/1ps
module ahpc_host_port
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CHIP_SELECT_LOW_ACTIVE_N,
  input wire logic CHIP_SELECT_HIGH_ACTIVE,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [11:0] DATA_IN,
  input wire logic [9:0] CONV_RESULT,
  input wire logic CONV_VALID,
  output logic [9:0] DATA_OUT,
  output logic DATA_OE,
  output logic READ_STROBE,
  output logic WORD_TAKEN,
  output logic [9:0] CTRL0,
  output logic DEVICE_IN_RESET,
  output logic SYNC_GEN_CLEAR,
  output logic OUTPUT_FORMAT_SELECT,
  output logic OFFSET_CAL_BUSY
);

  // offset calibration states
  typedef enum logic [2:0]
  {
    AHPC_CAL_IDLE = 3'b001,
    AHPC_CAL_WAIT = 3'b010,
    AHPC_CAL_DONE = 3'b100
  } ahpc_cal_t;

  // decode of a control word address, used for both registers
  function automatic logic is_addr(input logic [11:0] w, input logic lo);
    is_addr = (w[ahpc_pkg::AHPC_ADDR_HI_POS] == 1'b0) &&
              (w[ahpc_pkg::AHPC_ADDR_LO_POS] == lo);
  endfunction

  // pin combination, taken combinationally from the raw pin levels
  logic cs_ok; // both chip selects active
  logic dir_q, dir_d; // combined direction mode
  logic rd_req; // read request per current mode
  logic wr_req; // write request per current mode
  logic rd_int; // internal read strobe
  logic wr_int; // internal write strobe
  logic wr_int_q, wr_int_d; // delayed write strobe for edge
  logic wr_rise; // one cycle at start of a write

  // register state
  logic [11:0] cr1_q, cr1_d; // interface_and_format_control
  logic [9:0] cr0_q, cr0_d; // low ten bits of control register zero
  logic sync_q, sync_d; // one-cycle sync clear pulse
  logic taken_q, taken_d; // word accepted pulse
  logic [9:0] offs_q, offs_d; // stored offset
  ahpc_cal_t cal_q, cal_d; // calibration state
  logic [9:0] dout_q, dout_d; // output word
  logic oe_q, oe_d; // driver enable
  logic rs_q, rs_d; // read strobe copy
  logic [9:0] corr; // offset-corrected result
  logic busy_q, busy_d; // calibration running, kept in a flop for the pin

  always_comb
  begin
    cs_ok = !CHIP_SELECT_LOW_ACTIVE_N && CHIP_SELECT_HIGH_ACTIVE;
    if (dir_q)
    begin
      // read pin ignored; write pin high means read
      rd_req = WR_N; // see R7
      wr_req = !WR_N; // see R7
    end
    else
    begin
      // separate pins, each only while the other is idle
      rd_req = !RD_N && WR_N; // see R8
      wr_req = !WR_N && RD_N; // see R8
    end
    // and of all three: last active asserts, first inactive drops
    rd_int = cs_ok && rd_req; // see R11 R12
    wr_int = cs_ok && wr_req; // see R14 R15
    wr_rise = wr_int && !wr_int_q;
  end

  // next values of the control registers
  always_comb
  begin
    cr1_d = cr1_q;
    cr0_d = cr0_q;
    dir_d = cr1_q[ahpc_pkg::AHPC_DIR_MODE_POS];
    wr_int_d = wr_int;
    sync_d = 1'b0;
    taken_d = 1'b0;
    if (wr_rise)
    begin
      taken_d = 1'b1;
      if (is_addr(DATA_IN, 1'b1))
      begin
        // word stored once per strobe, at its start
        cr1_d = DATA_IN; // see R1 R16
        sync_d = DATA_IN[ahpc_pkg::AHPC_SYNC_CLR_POS]; // see R4
        if (DATA_IN[ahpc_pkg::AHPC_DEV_RESET_POS])
        begin
          // reset both registers, keep reset bit set
          cr1_d = ahpc_pkg::AHPC_CR1_RESET; // see R2
          cr1_d[ahpc_pkg::AHPC_DEV_RESET_POS] = 1'b1; // see R3
          cr0_d = ahpc_pkg::AHPC_CR0_RESET; // see R2
        end
      end
      else if (is_addr(DATA_IN, 1'b0) &&
               !cr1_q[ahpc_pkg::AHPC_DEV_RESET_POS])
      begin
        // register zero ignored while held in reset
        cr0_d = DATA_IN[9:0]; // see R16
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cr1_q <= ahpc_pkg::AHPC_CR1_RESET;
      cr0_q <= ahpc_pkg::AHPC_CR0_RESET;
      dir_q <= 1'b0;
      wr_int_q <= 1'b0;
      sync_q <= 1'b0;
      taken_q <= 1'b0;
    end
    else
    begin
      cr1_q <= cr1_d;
      cr0_q <= cr0_d;
      dir_q <= dir_d;
      wr_int_q <= wr_int_d;
      sync_q <= sync_d;
      taken_q <= taken_d;
    end
  end

  // offset calibration and output path
  always_comb
  begin
    cal_d = cal_q;
    offs_d = offs_q;
    corr = CONV_RESULT - offs_q; // see R10
    unique case (cal_q)
      AHPC_CAL_IDLE:
      begin
        // a write with the offset bit starts calibration
        if (wr_rise && is_addr(DATA_IN, 1'b1) &&
            DATA_IN[ahpc_pkg::AHPC_OFFS_POS] &&
            !DATA_IN[ahpc_pkg::AHPC_DEV_RESET_POS])
          cal_d = AHPC_CAL_WAIT; // see R10
      end
      AHPC_CAL_WAIT:
      begin
        // the next result is from zeroed inputs
        if (CONV_VALID)
        begin
          offs_d = CONV_RESULT; // see R10
          cal_d = AHPC_CAL_DONE;
        end
      end
      AHPC_CAL_DONE:
      begin
        cal_d = AHPC_CAL_IDLE;
      end
    endcase
    if (cr1_q[ahpc_pkg::AHPC_DEV_RESET_POS])
    begin
      // device reset drops any stored offset
      offs_d = ahpc_pkg::AHPC_ZERO_W; // see R2
      cal_d = AHPC_CAL_IDLE;
    end
    // busy pin registered from the next state so it keeps the state's timing
    busy_d = (cal_d != AHPC_CAL_IDLE); // see R10
    // format applied after correction
    if (cr1_q[ahpc_pkg::AHPC_FMT_POS])
      dout_d = corr ^ ahpc_pkg::AHPC_MSB_FLIP; // see R9
    else
      dout_d = corr; // see R9
    // drivers enabled only by the read strobe
    oe_d = rd_int; // see R13
    rs_d = rd_int; // see R13
    if (!rd_int)
      dout_d = ahpc_pkg::AHPC_ZERO_W;
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cal_q <= AHPC_CAL_IDLE;
      offs_q <= ahpc_pkg::AHPC_ZERO_W;
      dout_q <= ahpc_pkg::AHPC_ZERO_W;
      oe_q <= 1'b0;
      rs_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      cal_q <= cal_d;
      offs_q <= offs_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      rs_q <= rs_d;
      busy_q <= busy_d;
    end
  end

  // outputs straight from flip-flops
  assign DATA_OUT = dout_q;
  assign DATA_OE = oe_q;
  assign READ_STROBE = rs_q;
  assign WORD_TAKEN = taken_q;
  assign CTRL0 = cr0_q;
  assign DEVICE_IN_RESET = cr1_q[ahpc_pkg::AHPC_DEV_RESET_POS];
  assign SYNC_GEN_CLEAR = sync_q;
  assign OUTPUT_FORMAT_SELECT = cr1_q[ahpc_pkg::AHPC_FMT_POS];
  assign OFFSET_CAL_BUSY = busy_q;

  // driver enable follows the read strobe one cycle later
  read_enable_a: assert property (@(posedge CLK) // see R13
    disable iff (RESET)
    (cs_ok && rd_req) |=> DATA_OE && READ_STROBE)
    else $error("drivers not enabled after read strobe");
  // no read strobe while chip select is missing
  read_drop_a: assert property (@(posedge CLK) // see R12
    disable iff (RESET)
    !cs_ok |=> !DATA_OE)
    else $error("drivers on without chip select");
  // separate mode never reads with write low
  sep_read_a: assert property (@(posedge CLK) // see R11
    disable iff (RESET)
    (!dir_q && !WR_N) |=> !DATA_OE)
    else $error("read strobe during write");
  // combined mode reads with write pin high regardless of read pin
  comb_read_a: assert property (@(posedge CLK) // see R7
    disable iff (RESET)
    (dir_q && cs_ok && WR_N) |=> DATA_OE)
    else $error("combined mode read missed");
  // a register one write lands the next cycle
  cr1_load_a: assert property (@(posedge CLK) // see R16 R9
    disable iff (RESET)
    (wr_rise && is_addr(DATA_IN, 1'b1) &&
     !DATA_IN[ahpc_pkg::AHPC_DEV_RESET_POS]) |=>
    OUTPUT_FORMAT_SELECT == $past(DATA_IN[ahpc_pkg::AHPC_FMT_POS]))
    else $error("format bit not loaded");
  // reset bit write holds device in reset with defaults
  dev_reset_a: assert property (@(posedge CLK) // see R2
    disable iff (RESET)
    (wr_rise && is_addr(DATA_IN, 1'b1) &&
     DATA_IN[ahpc_pkg::AHPC_DEV_RESET_POS]) |=>
    DEVICE_IN_RESET && CTRL0 == ahpc_pkg::AHPC_CR0_RESET &&
    !OUTPUT_FORMAT_SELECT)
    else $error("device reset did not restore defaults");
  // held in reset until a write with bit 0 clear
  reset_hold_a: assert property (@(posedge CLK) // see R3
    disable iff (RESET)
    (DEVICE_IN_RESET && !wr_rise) |=> DEVICE_IN_RESET)
    else $error("device left reset without a write");
  // register zero keeps its default for as long as reset is held
  reset_ctrl0_a: assert property (@(posedge CLK) // see R2 R3
    disable iff (RESET)
    DEVICE_IN_RESET |-> CTRL0 == ahpc_pkg::AHPC_CR0_RESET)
    else $error("register zero changed while held in reset");
  // sync clear is a single pulse after the write
  sync_pulse_a: assert property (@(posedge CLK) // see R4
    disable iff (RESET)
    (wr_rise && is_addr(DATA_IN, 1'b1) &&
     DATA_IN[ahpc_pkg::AHPC_SYNC_CLR_POS]) |=>
    SYNC_GEN_CLEAR ##1 !SYNC_GEN_CLEAR)
    else $error("sync clear pulse wrong");
  // no sync clear without a write starting the cycle before
  sync_idle_a: assert property (@(posedge CLK) // see R4
    disable iff (RESET)
    !wr_rise |=> !SYNC_GEN_CLEAR)
    else $error("sync clear without a write");
  // write strobe never active together with read
  write_excl_a: assert property (@(posedge CLK) // see R14 R15
    disable iff (RESET)
    wr_rise |-> !rd_int)
    else $error("read and write strobes together");
  // data lines rest at zero whenever no read is strobed
  data_idle_a: assert property (@(posedge CLK) // see R13
    disable iff (RESET)
    !READ_STROBE |-> DATA_OUT == ahpc_pkg::AHPC_ZERO_W)
    else $error("data word shown without read strobe");
  // calibration start leads to wait state
  cal_start_a: assert property (@(posedge CLK) // see R10
    disable iff (RESET)
    (cal_q == AHPC_CAL_IDLE && wr_rise && is_addr(DATA_IN, 1'b1) &&
     DATA_IN[ahpc_pkg::AHPC_OFFS_POS] &&
     !DATA_IN[ahpc_pkg::AHPC_DEV_RESET_POS] && !DEVICE_IN_RESET) |=>
    OFFSET_CAL_BUSY)
    else $error("offset calibration not started");
  // the first result seen while waiting becomes the stored offset
  offs_take_a: assert property (@(posedge CLK) // see R10
    disable iff (RESET)
    (cal_q == AHPC_CAL_WAIT && CONV_VALID && !DEVICE_IN_RESET) |=>
    offs_q == $past(CONV_RESULT))
    else $error("offset not captured from result");
endmodule

/* File: verif/ahpc_conv_model.sv */
// conversion core stand-in that feeds periodic results to the host port
`timescale 1ns/1ps
module ahpc_conv_model
#(
  parameter int PERIOD = 4 // cycles between results; raise it for a slow core
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] sample,
  output logic [9:0] conv_result,
  output logic conv_valid
);
  int cnt_q; // position within one result period
  // pulse valid once a period; the word stands between pulses as a core
  // output register would, so reads at any time see the last result
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= 0;
      conv_valid <= 1'b0;
      conv_result <= 10'h000;
    end
    else
    begin
      cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      conv_valid <= (cnt_q == PERIOD - 1);
      if (cnt_q == PERIOD - 1)
        conv_result <= sample;
    end
  end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the host port and interface control register
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n = 1'b1; // low-active select, idle high
  logic cs_h = 1'b0; // high-active select, idle low
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic comb = 1'b0; // bench copy of the combined direction mode
  logic [11:0] din = 12'h000;
  logic [9:0] sample = 10'h015; // core input, two's complement
  logic [9:0] conv_result, data_out, ctrl0, rword;
  logic conv_valid, data_oe, read_strobe, word_taken;
  logic dev_rst, sync_clr, fmt_sel, cal_busy, sync_seen;
  int num_errors = 0;
  int compares = 0;
  int i;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  ahpc_conv_model #(.PERIOD(4)) core (.clk(clk), .reset(reset),
    .sample(sample), .conv_result(conv_result), .conv_valid(conv_valid));
  ahpc_host_port dut (.CLK(clk), .RESET(reset),
    .CHIP_SELECT_LOW_ACTIVE_N(cs_n), .CHIP_SELECT_HIGH_ACTIVE(cs_h),
    .RD_N(rd_n), .WR_N(wr_n), .DATA_IN(din), .CONV_RESULT(conv_result),
    .CONV_VALID(conv_valid), .DATA_OUT(data_out), .DATA_OE(data_oe),
    .READ_STROBE(read_strobe), .WORD_TAKEN(word_taken), .CTRL0(ctrl0),
    .DEVICE_IN_RESET(dev_rst), .SYNC_GEN_CLEAR(sync_clr),
    .OUTPUT_FORMAT_SELECT(fmt_sel), .OFFSET_CAL_BUSY(cal_busy));
  // compare one value, count it, report a mismatch
  task automatic check(input string what, input logic [11:0] seen,
    input logic [11:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // counts, verdict, end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one write: strobe held over one edge, then a full idle cycle
  task automatic wr(input logic [11:0] word);
    @(negedge clk);
    {cs_n, cs_h, wr_n, rd_n} = 4'h5; // read pin stays high
    din = word;
    @(negedge clk);
    check("word_taken", {11'h0, word_taken}, 12'h001);
    sync_seen = sync_clr;
    {cs_n, cs_h, wr_n} = 3'h5;
    @(negedge clk);
  endtask
  // one read; the high-active select drops first, the rest a cycle later
  task automatic rd(output logic [9:0] w);
    @(negedge clk);
    {cs_n, cs_h, wr_n} = 3'h3;
    rd_n = comb; // combined mode keeps the read pin high
    @(negedge clk);
    check("data_oe", {11'h0, data_oe}, 12'h001);
    check("read_strobe", {11'h0, read_strobe}, 12'h001);
    w = data_out;
    cs_h = 1'b0;
    @(negedge clk);
    check("oe_drop", {11'h0, data_oe}, 12'h000);
    check("data_idle", {2'h0, data_out}, 12'h000);
    {cs_n, rd_n} = 2'h3;
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check("ctrl0", {2'h0, ctrl0}, 12'h020);
    check("in_reset", {11'h0, dev_rst}, 12'h000);
    $display("test reset values done");
    // straight binary output flips the msb
    wr(12'h4B0);
    check("format", {11'h0, fmt_sel}, 12'h001);
    repeat (8) @(negedge clk);
    rd(rword);
    check("binary_word", {2'h0, rword}, 12'h215);
    $display("test format done");
    // both pins low in separate mode: neither strobe may start
    @(negedge clk);
    din = 12'h431;
    {cs_n, cs_h, rd_n, wr_n} = 4'h4;
    repeat (2) @(negedge clk);
    check("clash_read", {11'h0, read_strobe}, 12'h000);
    check("clash_write", {11'h0, word_taken}, 12'h000);
    check("clash_reset", {11'h0, dev_rst}, 12'h000);
    {cs_n, cs_h, rd_n, wr_n} = 4'hB;
    $display("test strobe clash done");
    wr(12'h432);
    check("sync_clear", {11'h0, sync_seen}, 12'h001);
    check("sync_pulse", {11'h0, sync_clr}, 12'h000);
    $display("test sync clear done");
    // reset bit stores defaults and holds the device until cleared
    wr(12'h4B1);
    check("in_reset", {11'h0, dev_rst}, 12'h001);
    check("format", {11'h0, fmt_sel}, 12'h000);
    wr(12'h021);
    check("ctrl0_held", {2'h0, ctrl0}, 12'h020);
    wr(12'h430);
    check("in_reset", {11'h0, dev_rst}, 12'h000);
    wr(12'h021);
    check("ctrl0", {2'h0, ctrl0}, 12'h021);
    $display("test device reset done");
    // combined mode: write pin high reads, low writes
    wr(12'h470);
    comb = 1'b1;
    rd(rword);
    check("comb_word", {2'h0, rword}, 12'h015);
    wr(12'h430);
    comb = 1'b0;
    rd(rword);
    check("sep_word", {2'h0, rword}, 12'h015);
    $display("test direction mode done");
    // offset capture, then subtraction from later results
    sample = 10'h005;
    wr(12'h530);
    for (i = 0; i < 40 && cal_busy !== 1'b0; i++)
      @(negedge clk);
    check("cal_done", {11'h0, cal_busy}, 12'h000);
    sample = 10'h015;
    repeat (8) @(negedge clk);
    rd(rword);
    check("offset_word", {2'h0, rword}, 12'h010);
    $display("test offset done");
    report_and_stop();
  end
endmodule
